// ==== hw/mmdia_regs.vh ====
/*
 * constants for the indirect extended-register access block:
 * management register numbers, control word fields, access functions,
 * supported device spaces and reset values.
 * assumes it is included by bare name from design files under hw/.
 */
`ifndef MMDIA_REGS_VH
`define MMDIA_REGS_VH

// direct management register numbers (5-bit register field of a frame)
`define MMDIA_REG_ACCESS_CTRL   5'h0D
`define MMDIA_REG_ADDRESS_DATA  5'h0E

// access control word layout
`define MMDIA_FUNC_MSB          15
`define MMDIA_FUNC_LSB          14
`define MMDIA_SPACE_MSB         4
`define MMDIA_SPACE_LSB         0

// access functions
`define MMDIA_FUNC_ADDRESS      2'h0
`define MMDIA_FUNC_DATA         2'h1
`define MMDIA_FUNC_INC_RW       2'h2
`define MMDIA_FUNC_INC_WR       2'h3

// supported device-space selects
`define MMDIA_SPACE_VENDOR      5'h1F
`define MMDIA_SPACE_PMA         5'h01
`define MMDIA_SPACE_VS3         5'h03
`define MMDIA_SPACE_VS7         5'h07

// reset values and step
`define MMDIA_CTRL_RESET        16'h0000
`define MMDIA_ADDR_RESET        16'h0000
`define MMDIA_DATA_ZERO         16'h0000
`define MMDIA_ADDR_STEP         16'h0001
`define MMDIA_SPACE_RESET       5'h00

`endif

// ==== hw/mmdia_addr_reg.v ====
/*
 * extended address register: 16-bit store with load and post increment.
 * assumes load and increment come from the same clock domain and are
 * never both asserted in one cycle (load wins if they are).
 */
`timescale 1ns/1ps
`default_nettype none
`include "mmdia_regs.vh"

module mmdia_addr_reg (
    input  wire        clk_sys,
    input  wire        rst_b,
    input  wire        load,
    input  wire [15:0] load_val,
    input  wire        inc,
    output wire [15:0] addr
);

    reg  [15:0] addr_ff;
    reg  [15:0] nxt_addr;

    // load has priority; increment wraps all-ones back to zero
    always @* begin
        nxt_addr = addr_ff;
        if (load) begin
            nxt_addr = load_val;
        end else if (inc) begin
            nxt_addr = addr_ff + `MMDIA_ADDR_STEP;
        end
    end

    // cleared on device reset
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            addr_ff <= `MMDIA_ADDR_RESET;
        end else begin
            addr_ff <= nxt_addr;
        end
    end

    assign addr = addr_ff;

endmodule // mmdia_addr_reg

`default_nettype wire

// ==== hw/mmdia_top.v ====
/*
 * indirect access to the extended register spaces through two directly
 * addressed management registers (access control and address/data).
 * assumes the serial management frame decoder runs on clk_sys and hands
 * each decoded access over as a one-cycle request, and that the extended
 * register file answers each request with a one-cycle ack on clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mmdia_regs.vh"

module mmdia_top (
    input  wire        clk_sys,
    input  wire        rst_b,
    // management register access from the frame decoder
    input  wire        mgmt_req,
    input  wire        mgmt_wr,
    input  wire [4:0]  mgmt_reg,
    input  wire [15:0] mgmt_wdata,
    output wire        mgmt_busy,
    output wire        mgmt_ack,
    output wire [15:0] mgmt_rdata,
    // extended register file access
    output wire        ext_req,
    output wire        ext_wr,
    output wire [4:0]  ext_space,
    output wire [15:0] ext_addr,
    output wire [15:0] ext_wdata,
    input  wire        ext_ack,
    input  wire [15:0] ext_rdata,
    // state visible to the rest of the device
    output wire [15:0] mmd_access_control,
    output wire [15:0] extended_address
);

    // one-hot states
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_EXT  = 2'b10;

    reg  [1:0]  state_ff;
    reg  [1:0]  nxt_state;
    reg  [15:0] ctrl_ff;
    reg  [15:0] nxt_ctrl;
    reg         ack_ff;
    reg         nxt_ack;
    reg  [15:0] rdata_ff;
    reg  [15:0] nxt_rdata;
    reg         ext_req_ff;
    reg         nxt_ext_req;
    reg         ext_wr_ff;
    reg         nxt_ext_wr;
    reg  [4:0]  ext_space_ff;
    reg  [4:0]  nxt_ext_space;
    reg  [15:0] ext_wdata_ff;
    reg  [15:0] nxt_ext_wdata;
    reg         addr_load;
    reg         addr_inc;

    wire [15:0] addr_cur;
    wire [1:0]  func;
    wire [4:0]  space;
    wire        space_ok;
    wire        hit_ctrl;
    wire        hit_addat;

    // control word fields
    // the function is read live from the control word, never copied
    assign func  = ctrl_ff[`MMDIA_FUNC_MSB:`MMDIA_FUNC_LSB];
    assign space = ctrl_ff[`MMDIA_SPACE_MSB:`MMDIA_SPACE_LSB];

    // only the four implemented spaces are honoured; pma is one of them
    // a bad space still lets the control word be rewritten, see the sequencer
    assign space_ok = (space == `MMDIA_SPACE_VENDOR) ||
                      (space == `MMDIA_SPACE_PMA)    ||
                      (space == `MMDIA_SPACE_VS3)    ||
                      (space == `MMDIA_SPACE_VS7);

    // direct register decode
    // other register numbers are answered but have no effect here
    assign hit_ctrl  = (mgmt_reg == `MMDIA_REG_ACCESS_CTRL);
    assign hit_addat = (mgmt_reg == `MMDIA_REG_ADDRESS_DATA);

    // extended address register, shared by all spaces
    mmdia_addr_reg u_addr (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .load     (addr_load),
        .load_val (mgmt_wdata),
        .inc      (addr_inc),
        .addr     (addr_cur)
    );

    // access sequencer: direct accesses finish in one cycle, data accesses
    // wait for the extended register file; no new request is taken while
    // waiting, so the address cannot move under an access in flight
    // limitation: a request that arrives while busy is dropped, so the
    // decoder must watch mgmt_busy and hold or retry its access
    always @* begin
        nxt_state     = state_ff;
        nxt_ctrl      = ctrl_ff;
        nxt_ack       = 1'b0;
        nxt_rdata     = rdata_ff;
        nxt_ext_req   = ext_req_ff;
        nxt_ext_wr    = ext_wr_ff;
        nxt_ext_space = ext_space_ff;
        nxt_ext_wdata = ext_wdata_ff;
        addr_load     = 1'b0;
        addr_inc      = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (mgmt_req) begin
                    nxt_ack   = 1'b1;
                    nxt_rdata = `MMDIA_DATA_ZERO;
                    if (hit_ctrl) begin
                        // control is always writable so a bad space can be corrected
                        if (mgmt_wr) begin
                            nxt_ctrl = mgmt_wdata;
                        end else begin
                            nxt_rdata = ctrl_ff;
                        end
                    end else if (hit_addat && space_ok) begin
                        if (func == `MMDIA_FUNC_ADDRESS) begin
                            if (mgmt_wr) begin
                                addr_load = 1'b1;
                            end else begin
                                nxt_rdata = addr_cur;
                            end
                        end else begin
                            // data function: hand over to the extended file
                            nxt_ack       = 1'b0;
                            nxt_state     = ST_EXT;
                            nxt_ext_req   = 1'b1;
                            nxt_ext_wr    = mgmt_wr;
                            nxt_ext_space = space;
                            nxt_ext_wdata = mgmt_wdata;
                        end
                    end
                    // other direct registers and ignored accesses read as zero
                end
            end
            ST_EXT: begin
                // ext_ack only counts while a request is out; the state alone says so
                if (ext_ack) begin
                    nxt_ack     = 1'b1;
                    nxt_state   = ST_IDLE;
                    nxt_ext_req = 1'b0;
                    if (!ext_wr_ff) begin
                        nxt_rdata = ext_rdata;
                    end
                    // post increment once the access is complete
                    // the wrap at all ones is left to the address register module
                    if (func == `MMDIA_FUNC_INC_RW) begin
                        addr_inc = 1'b1;
                    end else if (func == `MMDIA_FUNC_INC_WR) begin
                        addr_inc = ext_wr_ff;
                    end
                end
            end
            default: begin
                nxt_state   = ST_IDLE;
                nxt_ext_req = 1'b0;
            end
        endcase
    end

    // state and output registers
    // everything clears on reset so an access cut by reset leaves nothing half done
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_ff     <= ST_IDLE;
            ctrl_ff      <= `MMDIA_CTRL_RESET;
            ack_ff       <= 1'b0;
            rdata_ff     <= `MMDIA_DATA_ZERO;
            ext_req_ff   <= 1'b0;
            ext_wr_ff    <= 1'b0;
            ext_space_ff <= `MMDIA_SPACE_RESET;
            ext_wdata_ff <= `MMDIA_DATA_ZERO;
        end else begin
            state_ff     <= nxt_state;
            ctrl_ff      <= nxt_ctrl;
            ack_ff       <= nxt_ack;
            rdata_ff     <= nxt_rdata;
            ext_req_ff   <= nxt_ext_req;
            ext_wr_ff    <= nxt_ext_wr;
            ext_space_ff <= nxt_ext_space;
            ext_wdata_ff <= nxt_ext_wdata;
        end
    end

    // busy is combinational so the decoder can hold off its next request
    // rdata holds until the next request is taken, so a slow decoder can still pick it up
    assign mgmt_busy          = (state_ff == ST_EXT);
    assign mgmt_ack           = ack_ff;
    assign mgmt_rdata         = rdata_ff;
    assign ext_req            = ext_req_ff;
    assign ext_wr             = ext_wr_ff;
    assign ext_space          = ext_space_ff;
    assign ext_addr           = addr_cur; // stable: frozen while busy
    assign ext_wdata          = ext_wdata_ff;
    assign mmd_access_control = ctrl_ff;
    assign extended_address   = addr_cur;

endmodule // mmdia_top

`default_nettype wire

// ==== tb/mmdia_checker.sv ====
/* port checker for mmdia_top.
   assumes one clock clk_sys and async active-low rst_b. */
`timescale 1ns/1ps
`default_nettype none
module mmdia_checker (
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic        mgmt_req,
    input wire logic        mgmt_wr,
    input wire logic [4:0]  mgmt_reg,
    input wire logic [15:0] mgmt_wdata,
    input wire logic        mgmt_busy,
    input wire logic        mgmt_ack,
    input wire logic [15:0] mgmt_rdata,
    input wire logic        ext_req,
    input wire logic        ext_wr,
    input wire logic [4:0]  ext_space,
    input wire logic [15:0] ext_addr,
    input wire logic [15:0] ext_wdata,
    input wire logic        ext_ack,
    input wire logic [15:0] ext_rdata,
    input wire logic [15:0] mmd_access_control,
    input wire logic [15:0] extended_address
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // decoded request; a dropped request while busy must not count as taken
    wire       take = mgmt_req && !mgmt_busy;
    wire       on_ad = take && mgmt_reg == 5'h0E;
    wire [1:0] fn = mmd_access_control[15:14];
    wire [4:0] sp = mmd_access_control[4:0];
    wire       sp_ok = sp == 5'h1F || sp == 5'h01 || sp == 5'h03 || sp == 5'h07;
    wire       done = ext_req && ext_ack;
    wire [15:0] step = (fn == 2'h2 || (fn == 2'h3 && ext_wr)) ? 16'h0001 : 16'h0000;
    chk_ctrl_store: assert property (take && mgmt_wr && mgmt_reg == 5'h0D
        |=> mgmt_ack && mmd_access_control == $past(mgmt_wdata)) else $error("control not stored");
    chk_addr_load: assert property (on_ad && mgmt_wr && fn == 2'h0 && sp_ok
        |=> mgmt_ack && extended_address == $past(mgmt_wdata)) else $error("address not loaded");
    chk_addr_read: assert property (on_ad && !mgmt_wr && fn == 2'h0 && sp_ok
        |=> mgmt_ack && mgmt_rdata == extended_address) else $error("address read wrong");
    chk_space_drop: assert property (on_ad && !sp_ok
        |=> mgmt_ack && !ext_req && $stable(extended_address)) else $error("bad space acted on");
    chk_req_hold: assert property (ext_req && !ext_ack
        |=> ext_req && $stable(ext_addr) && $stable(ext_wdata) && $stable(ext_wr)) else $error("request moved");
    chk_addr_step: assert property (done
        |=> extended_address == $past(ext_addr) + $past(step)) else $error("address step wrong");
    chk_rd_pass: assert property (done && !ext_wr
        |=> mgmt_ack && mgmt_rdata == $past(ext_rdata)) else $error("read data lost");
    chk_busy_track: assert property (ext_req
        |-> mgmt_busy && $stable(mmd_access_control)) else $error("busy or control moved during access");
    chk_reset_zero: assert property ($rose(rst_b)
        |-> mmd_access_control == 16'h0000 && extended_address == 16'h0000) else $error("reset value");
    cover property (done && fn == 2'h2);
    cover property (done && fn == 2'h3 && !ext_wr);
    cover property (on_ad && !sp_ok);
endmodule // mmdia_checker
bind mmdia_top mmdia_checker chk_u (.*);
`default_nettype wire

// ==== tb/mmdia_ext_model.sv ====
/* extended register file model, answering after wait_n idle cycles.
   assumes the requester holds its access until ext_ack. */
`timescale 1ns/1ps
`default_nettype none
module mmdia_ext_model (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        ext_req,
    input  wire logic        ext_wr,
    input  wire logic [15:0] ext_addr,
    input  wire logic [15:0] ext_wdata,
    input  wire logic [3:0]  wait_n,
    output var  logic        ext_ack,
    output var  logic [15:0] ext_rdata
);
    logic [15:0] mem_ff [0:255];
    logic [3:0]  cnt_ff;
    // read bus flips between answers so stale data never passes for fresh
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff <= 4'h0;
            ext_ack <= 1'b0;
            ext_rdata <= 16'h0000;
            // unwritten registers read as all ones, never as unknown
            for (int j = 0; j < 256; j++) mem_ff[j] <= 16'hFFFF;
        end else begin
            ext_ack <= 1'b0;
            ext_rdata <= ~ext_rdata;
            if (ext_req && !ext_ack) begin
                cnt_ff <= cnt_ff + 4'h1;
                if (cnt_ff == wait_n) begin
                    cnt_ff <= 4'h0;
                    ext_ack <= 1'b1;
                    ext_rdata <= mem_ff[ext_addr[7:0]];
                    if (ext_wr) mem_ff[ext_addr[7:0]] <= ext_wdata;
                end
            end
        end
    end
endmodule // mmdia_ext_model
`default_nettype wire

// ==== tb/test_mmdia_top.sv ====
/* self-checking bench for mmdia_top with the file model.
   assumes every taken request is answered by mgmt_ack. */
`timescale 1ns/1ps
`default_nettype none
module test_mmdia_top;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic        mgmt_req = 1'b0;
    logic        mgmt_wr = 1'b0;
    logic [4:0]  mgmt_reg = 5'h00;
    logic [15:0] mgmt_wdata = 16'h0000;
    logic [3:0]  wait_n = 4'h0;
    wire         mgmt_busy, mgmt_ack, ext_req, ext_wr, ext_ack;
    wire  [4:0]  ext_space;
    wire  [15:0] mgmt_rdata, ext_addr, ext_wdata, ext_rdata, mmd_access_control, extended_address;
    int          fails = 0;
    int          n_tests = 0;
    logic [15:0] rd;
    mmdia_top dut_u (.*);
    mmdia_ext_model ext_u (.*);
    always #25 clk_sys = ~clk_sys;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one access: a one-cycle pulse, then a bounded wait for the answer
    task automatic acc(input logic wr, input logic [4:0] rg, input logic [15:0] wd);
        int i;
        @(posedge clk_sys) #1;
        mgmt_req = 1'b1;
        mgmt_wr = wr;
        mgmt_reg = rg;
        mgmt_wdata = wd;
        @(posedge clk_sys) #1;
        mgmt_req = 1'b0;
        for (i = 0; i < 40 && mgmt_ack !== 1'b1; i++) @(posedge clk_sys) #1;
        rd = mgmt_rdata;
        if (i == 40) begin
            fails++;
            summarize();
        end
    endtask
    task automatic setad(input logic [4:0] sp, input logic [15:0] a);
        acc(1'b1, 5'h0D, {11'h000, sp});
        acc(1'b1, 5'h0E, a);
    endtask
    task automatic t_addr;
        check(mmd_access_control, 16'h0000);
        check(extended_address, 16'h0000);
        setad(5'h1F, 16'h1234);
        check(extended_address, 16'h1234);
        acc(1'b1, 5'h0D, 16'h0001);
        check(mmd_access_control, 16'h0001);
        acc(1'b0, 5'h0E, 16'h0000);
        check(rd, 16'h1234);
    endtask
    // repeated data accesses stay on one register, also with a slow file
    task automatic t_data;
        acc(1'b1, 5'h0D, 16'h401F);
        acc(1'b1, 5'h0E, 16'hA5A5);
        acc(1'b1, 5'h0E, 16'h5A5A);
        acc(1'b0, 5'h0E, 16'h0000);
        check(rd, 16'h5A5A);
        check({11'h000, ext_space}, 16'h001F);
        wait_n = 4'h3;
        acc(1'b1, 5'h0D, 16'h4001);
        acc(1'b0, 5'h0E, 16'h0000);
        check(rd, 16'h5A5A);
        check(extended_address, 16'h1234);
        check({11'h000, ext_space}, 16'h0001);
    endtask
    task automatic t_inc;
        int k;
        setad(5'h1F, 16'h0010);
        acc(1'b1, 5'h0D, 16'h801F);
        for (k = 0; k < 3; k++) acc(1'b1, 5'h0E, 16'h0100 + k[15:0]);
        check(extended_address, 16'h0013);
        setad(5'h1F, 16'h0010);
        acc(1'b1, 5'h0D, 16'h801F);
        for (k = 0; k < 3; k++) begin
            acc(1'b0, 5'h0E, 16'h0000);
            check(rd, 16'h0100 + k[15:0]);
        end
        acc(1'b1, 5'h0D, 16'hC01F);
        acc(1'b0, 5'h0E, 16'h0000);
        check(extended_address, 16'h0013);
        acc(1'b1, 5'h0E, 16'h0BAD);
        check(extended_address, 16'h0014);
    endtask
    // wrap at all ones, then an unsupported space must change nothing
    task automatic t_edge;
        setad(5'h01, 16'hFFFF);
        acc(1'b1, 5'h0D, 16'h8001);
        acc(1'b1, 5'h0E, 16'h0042);
        check(extended_address, 16'h0000);
        acc(1'b1, 5'h0D, 16'h4002);
        acc(1'b1, 5'h0E, 16'hBEEF);
        acc(1'b0, 5'h0E, 16'h0000);
        check(rd, 16'h0000);
        check(extended_address, 16'h0000);
    endtask
    // a reset in mid-run clears a programmed control word and address
    task automatic t_rst;
        setad(5'h07, 16'h00AA);
        check(extended_address, 16'h00AA);
        @(posedge clk_sys) #1;
        rst_b = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 rst_b = 1'b1;
        check(mmd_access_control, 16'h0000);
        check(extended_address, 16'h0000);
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        #1 rst_b = 1'b1;
        t_addr();
        t_data();
        t_inc();
        t_edge();
        t_rst();
        summarize();
    end
endmodule // test_mmdia_top
`default_nettype wire
